// ### verilog/cfg_status_bank.sv
/*
 configuration status/command and block soft reset registers.
 assumes a config-cycle decoder presents word address, strobes and data
 synchronous to clk, and that bus logic reports master/parity events as pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module cfg_status_bank
   import cfg_regs_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        cfg_write,
   input  wire logic        cfg_read,
   input  wire logic [7:0]  cfg_addr,
   input  wire logic [3:0]  cfg_byte_en,
   input  wire logic [31:0] cfg_wdata,
   output logic      [31:0] cfg_rdata,
   input  wire logic        master_abort_seen,
   input  wire logic        target_abort_seen,
   input  wire logic        data_perr_seen,
   input  wire logic        was_bus_master,
   input  wire logic        addr_perr_seen,
   input  wire logic        any_perr_seen,
   output logic             fast_back_to_back_enable,
   output logic             system_error_driver_enable,
   output logic             parity_error_response_enable,
   output logic             bus_master_enable,
   output logic             memory_space_enable,
   output logic             serr_pulse_oe,
   output logic             pcm_core_hold,
   output logic             local_bus_hold,
   output logic             local_dma_standby,
   output logic             serial_port_hold
);
   ////////////////////////////////////////////////////////////////////////////
   // decode
   wire sel_pci_status_and_command = cfg_addr == PCI_STATUS_AND_COMMAND_OFFSET;
   wire sel_reset   = cfg_addr == SOFT_RESET_OFFSET;
   wire wr_pci_status_and_command  = cfg_write & sel_pci_status_and_command;
   wire wr_reset    = cfg_write & sel_reset & cfg_byte_en[2];
   wire wr_cmd_lo   = wr_pci_status_and_command & cfg_byte_en[0];
   wire wr_cmd_hi   = wr_pci_status_and_command & cfg_byte_en[1];
   wire wr_sta_hi   = wr_pci_status_and_command & cfg_byte_en[3];

   ////////////////////////////////////////////////////////////////////////////
   // command bits
   logic [15:0] cmd_q;
   logic [15:0] cmd_d;
   // special cycle and io space bits stored and read back only; no output uses them
   assign cmd_d[7:0]  = wr_cmd_lo ? (cfg_wdata[7:0] & CMD_WRITABLE_MASK[7:0]) : cmd_q[7:0];
   assign cmd_d[15:8] = wr_cmd_hi ? (cfg_wdata[15:8] & CMD_WRITABLE_MASK[15:8])
                                  : cmd_q[15:8];
   always_ff @(posedge clk) begin
      if (!reset_n) cmd_q <= PCI_STATUS_AND_COMMAND_RESET[15:0];
      else          cmd_q <= cmd_d;
   end

   wire per_en  = cmd_q[BIT_PER];
   wire serr_en = cmd_q[BIT_SYSTEM_ERROR_DRIVER_ENABLE];

   ////////////////////////////////////////////////////////////////////////////
   // status error flags
   wire ev_dpe  = any_perr_seen;
   wire ev_sse  = serr_en & (master_abort_seen | target_abort_seen
                             | (addr_perr_seen & per_en));
   wire ev_data_parity_error_detected = data_perr_seen & was_bus_master & per_en;
   wire [4:0] ev_vec  = {ev_dpe, ev_sse, master_abort_seen, target_abort_seen, ev_data_parity_error_detected};
   wire [4:0] clr_vec = {5{wr_sta_hi}} & {cfg_wdata[31:28], cfg_wdata[24]};
   logic [4:0] flags_q;

   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++) begin : g_flag
         error_flag u_flag (
            .clk       (clk),
            .reset_n   (reset_n),
            .set_event (ev_vec[gi]),
            .clear_req (clr_vec[gi]),
            .flag_q    (flags_q[gi])
         );
      end
   endgenerate

   // fixed fields: 27 zero, 26:25 medium, 23 one, 22 and 21 zero
   wire [31:0] pci_status_and_command_word = STA_FIXED_BITS
                            | {flags_q[4:1], 3'h0, flags_q[0], 24'h000000}
                            | {16'h0000, cmd_q};

   ////////////////////////////////////////////////////////////////////////////
   // soft reset register
   logic [2:0] rst_bits;
   block_reset_ctrl u_rst (
      .clk          (clk),
      .reset_n      (reset_n),
      .write_en     (wr_reset),
      .write_bits   (cfg_wdata[BIT_PCM_CORE_RESET_CTRL+2:BIT_PCM_CORE_RESET_CTRL]),
      .reset_bits_q (rst_bits)
   );
   wire [31:0] soft_reset_word = {12'h000, rst_bits, 17'h00000} & SOFT_RESET_MASK;

   ////////////////////////////////////////////////////////////////////////////
   // read data register; unmapped words read zero
   wire [31:0] rdata_d = !cfg_read ? cfg_rdata
                       : sel_pci_status_and_command ? pci_status_and_command_word
                       : sel_reset ? soft_reset_word : 32'h00000000;

   // serr driver enable only while enabled and a system error event occurs
   wire serr_d = serr_en & ev_sse;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cfg_rdata                    <= 32'h00000000;
         fast_back_to_back_enable     <= 1'b0;
         system_error_driver_enable   <= 1'b0;
         parity_error_response_enable <= 1'b0;
         bus_master_enable            <= 1'b0;
         memory_space_enable          <= 1'b0;
         serr_pulse_oe                <= 1'b0;
         pcm_core_hold                <= 1'b0;
         local_bus_hold               <= 1'b0;
         local_dma_standby            <= 1'b0;
         serial_port_hold             <= 1'b0;
      end else begin
         cfg_rdata                    <= rdata_d;
         fast_back_to_back_enable     <= cmd_d[BIT_FAST_BACK_TO_BACK_ENABLE];
         system_error_driver_enable   <= cmd_d[BIT_SYSTEM_ERROR_DRIVER_ENABLE];
         parity_error_response_enable <= cmd_d[BIT_PER];
         bus_master_enable            <= cmd_d[BIT_BM];
         memory_space_enable          <= cmd_d[BIT_MS];
         serr_pulse_oe                <= serr_d;
         // holds follow the stored bits one edge later than the register
         pcm_core_hold                <= rst_bits[0];
         local_bus_hold               <= rst_bits[1];
         local_dma_standby            <= rst_bits[1];
         serial_port_hold             <= rst_bits[2];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   rma_sets_a: assert property (@(posedge clk) disable iff (!reset_n)
      master_abort_seen |=> flags_q[2]) else $error("master abort not flagged");
   rta_sets_a: assert property (@(posedge clk) disable iff (!reset_n)
      target_abort_seen |=> flags_q[1]) else $error("target abort not flagged");
   fixed_bits_a: assert property (@(posedge clk) disable iff (!reset_n)
      cfg_read && sel_pci_status_and_command |=> cfg_rdata[27:25] == 3'b001 && cfg_rdata[23:21] == 3'b100)
      else $error("fixed status bits wrong");
   data_parity_error_detected_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
      !flags_q[0] && !(data_perr_seen && was_bus_master && per_en) && !wr_sta_hi
      |=> !flags_q[0]) else $error("parity flag set without cause");
   zero_cmd_a: assert property (@(posedge clk) disable iff (!reset_n)
      cfg_read && sel_pci_status_and_command |=> cfg_rdata[7] == 1'b0 && cfg_rdata[5:4] == 2'h0)
      else $error("unimplemented command bits nonzero");
   serr_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
      !serr_en && !flags_q[3] && !wr_sta_hi |=> !flags_q[3])
      else $error("system error flag set while disabled");
   dpe_any_a: assert property (@(posedge clk) disable iff (!reset_n)
      any_perr_seen && !per_en |=> flags_q[4]) else $error("parity error missed");
   w1c_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
      wr_sta_hi && cfg_wdata[29] && !master_abort_seen |=> !flags_q[2])
      else $error("write one did not clear");
   hold_follow_a: assert property (@(posedge clk) disable iff (!reset_n)
      wr_reset |=> ##1 pcm_core_hold == $past(cfg_wdata[BIT_PCM_CORE_RESET_CTRL], 2))
      else $error("pcm hold not following control");
   rst_mask_a: assert property (@(posedge clk) disable iff (!reset_n)
      cfg_read && sel_reset |=> (cfg_rdata & ~SOFT_RESET_MASK) == 32'h00000000)
      else $error("soft reset reserved bits nonzero");
   bm_follow_a: assert property (@(posedge clk) disable iff (!reset_n)
      wr_cmd_lo |=> bus_master_enable == $past(cfg_wdata[BIT_BM]))
      else $error("bus master enable not updated");
   lbus_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
      wr_reset |=> ##1 local_bus_hold == $past(cfg_wdata[BIT_PCM_CORE_RESET_CTRL+1], 2)
                       && local_dma_standby == $past(cfg_wdata[BIT_PCM_CORE_RESET_CTRL+1], 2))
      else $error("local bus hold not following control");
   sport_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
      wr_reset |=> ##1 serial_port_hold == $past(cfg_wdata[BIT_PCM_CORE_RESET_CTRL+2], 2))
      else $error("serial port hold not following control");
   serr_oe_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
      !serr_en |=> !serr_pulse_oe)
      else $error("system error driver enabled while disabled");
   per_follow_a: assert property (@(posedge clk) disable iff (!reset_n)
      wr_cmd_lo |=> parity_error_response_enable == $past(cfg_wdata[BIT_PER]))
      else $error("parity response enable not updated");
endmodule : cfg_status_bank
`default_nettype wire

// ### verilog/cfg_regs_pkg.sv
/*
 constants for the configuration status/command and soft reset bank.
 assumes a single 10 MHz clock domain.
*/
package cfg_regs_pkg;
   localparam logic [7:0]  PCI_STATUS_AND_COMMAND_OFFSET     = 8'h04;
   localparam logic [7:0]  SOFT_RESET_OFFSET  = 8'h4C;
   localparam logic [31:0] SOFT_RESET_RESET   = 32'h00000000;
   localparam logic [31:0] PCI_STATUS_AND_COMMAND_RESET      = 32'h02800000;
   // bit positions
   localparam int BIT_DPE   = 31;
   localparam int BIT_SSE   = 30;
   localparam int BIT_RMA   = 29;
   localparam int BIT_RTA   = 28;
   localparam int BIT_DATA_PARITY_ERROR_DETECTED  = 24;
   localparam int BIT_FAST_BACK_TO_BACK_ENABLE  = 9;
   localparam int BIT_SYSTEM_ERROR_DRIVER_ENABLE = 8;
   localparam int BIT_PER   = 6;
   localparam int BIT_SC    = 3;
   localparam int BIT_BM    = 2;
   localparam int BIT_MS    = 1;
   localparam int BIT_IOS   = 0;
   localparam int BIT_PCM_CORE_RESET_CTRL  = 17;
   // fixed status field values
   localparam logic [1:0]  DEVSEL_MEDIUM      = 2'h1;
   localparam logic [31:0] STA_FIXED_BITS     = 32'h02800000;
   // bits 9, 8, 6 and 3:0 hold what the host writes; all others read zero
   localparam logic [15:0] CMD_WRITABLE_MASK  = 16'h034F;
   localparam logic [31:0] SOFT_RESET_MASK    = 32'h000E0000;
   localparam logic [31:0] W1C_MASK           = 32'hF1000000;
endpackage : cfg_regs_pkg

// ### verilog/error_flag.sv
/*
 one sticky error flag: set by a hardware event, cleared by a write of one.
 assumes clear pulses come from the register write path.
*/
`timescale 1ns/1ps
`default_nettype none
module error_flag (
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic set_event,
   input  wire logic clear_req,
   output var  logic flag_q
);
   logic flag_d;

   // set wins over a clear in the same cycle so no event is lost
   assign flag_d = set_event | (flag_q & ~clear_req);

   always_ff @(posedge clk) begin
      if (!reset_n) flag_q <= 1'b0;
      else          flag_q <= flag_d;
   end

   set_wins_a: assert property (@(posedge clk) disable iff (!reset_n)
      set_event |=> flag_q) else $error("event lost on flag");
endmodule : error_flag
`default_nettype wire

// ### verilog/block_reset_ctrl.sv
/*
 holds the three block reset controls for the bank to fan out as hold signals.
 assumes write strobe and data are synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module block_reset_ctrl
   import cfg_regs_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       write_en,
   input  wire logic [2:0] write_bits,
   output var  logic [2:0] reset_bits_q
);
   always_ff @(posedge clk) begin
      if (!reset_n)      reset_bits_q <= SOFT_RESET_RESET[BIT_PCM_CORE_RESET_CTRL+2:BIT_PCM_CORE_RESET_CTRL];
      else if (write_en) reset_bits_q <= write_bits;
   end

   // zero written clears the control at the next edge; the bank's hold releases the group one edge later
   release_follows_a: assert property (@(posedge clk) disable iff (!reset_n)
      write_en |=> reset_bits_q == $past(write_bits))
      else $error("reset control did not follow write");
endmodule : block_reset_ctrl
`default_nettype wire

// ### verification/cfg_host_model.sv
/*
 host model issuing single-word configuration reads and writes.
 assumes the bench calls its tasks from one process, clocked by clk.
*/
`timescale 1ns/1ps
`default_nettype none
module cfg_host_model (
   input  wire logic        clk,
   output var  logic        cfg_write,
   output var  logic        cfg_read,
   output var  logic [7:0]  cfg_addr,
   output var  logic [3:0]  cfg_byte_en,
   output var  logic [31:0] cfg_wdata
);
   initial begin
      cfg_write = 1'b0;
      cfg_read = 1'b0;
      cfg_addr = 8'hFF;
      cfg_byte_en = 4'h0;
      cfg_wdata = 32'h00000000;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // released address and data lines carry the inverse so a stale value can never pass as fresh
   task automatic drop(input logic [7:0] a, input logic [31:0] d);
      cfg_write <= 1'b0;
      cfg_read <= 1'b0;
      cfg_addr <= ~a;
      cfg_wdata <= ~d;
      cfg_byte_en <= 4'h0;
   endtask : drop
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
      @(posedge clk);
      cfg_write <= 1'b1;
      cfg_addr <= a;
      cfg_wdata <= d;
      cfg_byte_en <= be;
      @(posedge clk);
      drop(a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      cfg_read <= 1'b1;
      cfg_addr <= a;
      @(posedge clk);
      drop(a, cfg_wdata);
   endtask : rd
endmodule : cfg_host_model
`default_nettype wire

// ### verification/cfg_status_bank_tb_top.sv
/*
 self-checking bench for the status/command and soft reset bank.
 assumes the host model drives config cycles; the bench drives bus events.
*/
`timescale 1ns/1ps
`default_nettype none
module cfg_status_bank_tb_top;
   import cfg_regs_pkg::*;
   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic [5:0]  ev = 6'h00;
   logic        rd_seen = 1'b0;
   wire logic   cfg_write, cfg_read;
   wire logic [7:0]  cfg_addr;
   wire logic [3:0]  cfg_byte_en;
   wire logic [31:0] cfg_wdata;
   wire logic [31:0] cfg_rdata;
   wire logic [9:0]  en_o;
   int          miscompares = 0;
   int          n_checks = 0;
   int          seed = 37;
   logic [31:0] exp_q [$];
   logic [31:0] w, cmd;
   // events: ma, ta, data perr, was master, addr perr, any perr
   logic [5:0]  ev_tab [6] = '{6'h01, 6'h02, 6'h0C, 6'h10, 6'h20, 6'h04};
   logic [31:0] st_tab [12] = '{32'h60000000, 32'h50000000, 32'h01000000, 32'h40000000,
      32'h80000000, 32'h0, 32'h20000000, 32'h10000000, 32'h0, 32'h0, 32'h80000000, 32'h0};
   always #50 clk = ~clk;
   cfg_host_model i_cfg_host_model (.clk(clk), .cfg_write(cfg_write), .cfg_read(cfg_read),
      .cfg_addr(cfg_addr), .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata));
   cfg_status_bank i_cfg_status_bank (.clk(clk), .reset_n(reset_n), .cfg_write(cfg_write),
      .cfg_read(cfg_read), .cfg_addr(cfg_addr), .cfg_byte_en(cfg_byte_en),
      .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .master_abort_seen(ev[0]),
      .target_abort_seen(ev[1]), .data_perr_seen(ev[2]), .was_bus_master(ev[3]),
      .addr_perr_seen(ev[4]), .any_perr_seen(ev[5]), .fast_back_to_back_enable(en_o[9]),
      .system_error_driver_enable(en_o[8]), .parity_error_response_enable(en_o[6]),
      .bus_master_enable(en_o[2]), .memory_space_enable(en_o[1]), .serr_pulse_oe(en_o[0]),
      .pcm_core_hold(en_o[3]), .local_bus_hold(en_o[4]), .local_dma_standby(en_o[5]),
      .serial_port_hold(en_o[7]));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      i_cfg_host_model.rd(a);
   endtask : rd
   // level outputs checked mid-cycle, once the hold flops have landed
   task automatic chk_en(input logic [31:0] c, input logic [31:0] s);
      @(negedge clk);
      chk({23'h0, en_o[9:1]}, {23'h0, c[9], c[8], s[19], c[6], s[18], s[18], s[17], c[2], c[1]});
   endtask : chk_en
   task automatic conclude();
      $display("checks %0d, miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : conclude
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clk) rd_seen <= cfg_read;
   always @(negedge clk) begin
      if (rd_seen) begin
         chk(cfg_rdata, exp_q.pop_front());
      end
   end
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      conclude();
   end
   initial begin
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      rd(PCI_STATUS_AND_COMMAND_OFFSET, PCI_STATUS_AND_COMMAND_RESET);
      rd(SOFT_RESET_OFFSET, SOFT_RESET_RESET);
      for (int i = 0; i < 6; i++) begin
         w = $random(seed);
         cmd = w & {16'h0, CMD_WRITABLE_MASK};
         i_cfg_host_model.wr(PCI_STATUS_AND_COMMAND_OFFSET, w & 32'h0EFFFFFF, 4'hF);
         rd(PCI_STATUS_AND_COMMAND_OFFSET, PCI_STATUS_AND_COMMAND_RESET | cmd);
         chk_en(cmd, 0);
      end
      i_cfg_host_model.wr(PCI_STATUS_AND_COMMAND_OFFSET, 32'h0, 4'h1);
      rd(PCI_STATUS_AND_COMMAND_OFFSET, PCI_STATUS_AND_COMMAND_RESET | (cmd & 32'h300));
      i_cfg_host_model.wr(8'h48, 32'hFFFFFFFF, 4'hF);
      rd(8'h48, 32'h0);
      i_cfg_host_model.wr(SOFT_RESET_OFFSET, 32'hFFFFFFFF, 4'hF);
      rd(SOFT_RESET_OFFSET, SOFT_RESET_MASK);
      chk_en(cmd & 32'h300, SOFT_RESET_MASK);
      i_cfg_host_model.wr(SOFT_RESET_OFFSET, 32'h0, 4'hF);
      rd(SOFT_RESET_OFFSET, 32'h0);
      chk_en(cmd & 32'h300, 0);
      // bus master and memory space go on before any event traffic
      for (int i = 0; i < 12; i++) begin
         cmd = (i < 6) ? 32'h146 : 32'h006;
         i_cfg_host_model.wr(PCI_STATUS_AND_COMMAND_OFFSET, W1C_MASK | cmd, 4'hF);
         @(posedge clk);
         ev <= ev_tab[i % 6];
         @(posedge clk);
         ev <= 6'h00;
         @(negedge clk);
         chk({31'h0, en_o[0]}, {31'h0, st_tab[i][30]});
         rd(PCI_STATUS_AND_COMMAND_OFFSET, PCI_STATUS_AND_COMMAND_RESET | cmd | st_tab[i]);
         i_cfg_host_model.wr(PCI_STATUS_AND_COMMAND_OFFSET, cmd, 4'hF);
         rd(PCI_STATUS_AND_COMMAND_OFFSET, PCI_STATUS_AND_COMMAND_RESET | cmd | st_tab[i]);
      end
      i_cfg_host_model.wr(PCI_STATUS_AND_COMMAND_OFFSET, W1C_MASK, 4'hF);
      rd(PCI_STATUS_AND_COMMAND_OFFSET, PCI_STATUS_AND_COMMAND_RESET);
      repeat (3) @(posedge clk);
      conclude();
   end
endmodule : cfg_status_bank_tb_top
`default_nettype wire
